// File: hdl/heater_open_alarm.sv
// Heater burnout alarm core with Avalon-MM register slave
// Operation
// - Alarm works only while the heating output is a pulsed on/off output.
// - Alarm shows only on an output assigned to it: control 1/2, auxiliary 1/2.
// - Alarm asserts when measured heater current is below the threshold.
// - Thresholds 0.1 to 49.9 A, in tenths, are live comparison values.
// - Threshold 0.0 forces alarm off; 50.0 forces alarm on.
// - Latched alarm holds until threshold is written to 0.0 or power cycles.
// - Latching only with the latch option on; otherwise alarm follows compare.
// - Evaluate only after output has been on continuously for 190 ms.
// - Alarm never changes the heater drive.
// - Measured current is readable as a monitor value.
// - Current of 55.0 A or more reads as code FFFF.
// - Heater powered after the controller gives an alarm.
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "heater_alarm_regs.svh"

module heater_open_alarm #(
    parameter int unsigned MIN_ON_CYC = `HTR_MIN_ON_MS * `HTR_CLK_KHZ
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic heat_out_on,
    input wire logic [15:0] lead_current_sensor,
    input wire logic lead_current_valid,
    output logic heater_drive,
    output logic ctrl_out1,
    output logic ctrl_out2,
    output logic aux_out1,
    output logic aux_out2,
    output logic irq
);

    sample_if sif ();

    logic [4:0] ctrl_r;
    logic [`HTR_THR_W-1:0] thr_r;
    logic thr_zero_wr;
    heater_alarm_pkg::current_t mon_r;
    logic sampled_r;
    logic alarm_r;
    logic [`HTR_IRQ_W-1:0] irq_stat_r;
    logic [`HTR_IRQ_W-1:0] irq_mask_r;
    logic [`HTR_IRQ_W-1:0] irq_set;
    logic [`HTR_IRQ_W-1:0] alarm_rise_ev;
    logic wr_commit;
    logic pulsed_mode;
    logic latch_en;
    heater_alarm_pkg::out_assign_e out_sel;
    logic below_thr;

    // Clamp a written threshold to the forced-on value
    function automatic logic [`HTR_THR_W-1:0] f_clamp_thr(input logic [31:0] wd);
        if (wd > {23'h00_0000, `HTR_THR_FORCE})
            f_clamp_thr = `HTR_THR_FORCE;
        else
            f_clamp_thr = wd[`HTR_THR_W-1:0];
    endfunction

    // Monitor code from a current sample
    function automatic heater_alarm_pkg::current_t f_monitor(input heater_alarm_pkg::current_t cur);
        if (cur >= `HTR_CUR_OVR_LIMIT)
            f_monitor = `HTR_CUR_OVR_CODE;
        else
            f_monitor = cur;
    endfunction

    // Field views of the control register
    assign pulsed_mode = ctrl_r[`HTR_CTRL_PULSED];
    assign latch_en = ctrl_r[`HTR_CTRL_LATCH];
    assign out_sel = heater_alarm_pkg::out_assign_e'(ctrl_r[`HTR_CTRL_ASSIGN_HI:`HTR_CTRL_ASSIGN_LO]);

    // Feed the qualifier with the drive level and sensor readings
    assign sif.heat_on = heat_out_on;
    assign sif.meas = lead_current_sensor;
    assign sif.meas_valid = lead_current_valid;

    qualified_sampler #(
        .MIN_ON_CYC(MIN_ON_CYC)
    ) u_sampler (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .sif(sif)
    );

    // One wait cycle per access, write lands at the accepting edge
    assign wr_commit = avs_write && !avs_waitrequest;

    // Bus handshake and read data
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            if ((avs_read || avs_write) && avs_waitrequest)
            begin
                avs_waitrequest <= 1'b0;
                case (avs_address)
                    `HTR_OFS_CTRL: avs_readdata <= {27'h000_0000, ctrl_r};
                    `HTR_OFS_THRESH: avs_readdata <= {23'h00_0000, thr_r};
                    `HTR_OFS_MONITOR: avs_readdata <= {16'h0000, mon_r};
                    `HTR_OFS_STATUS: avs_readdata <= {30'h0000_0000, sampled_r, alarm_r};
                    `HTR_OFS_IRQ_STAT: avs_readdata <= {29'h0000_0000, irq_stat_r};
                    `HTR_OFS_IRQ_MASK: avs_readdata <= {29'h0000_0000, irq_mask_r};
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
            else
            begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    // Control and mask registers
    // latch option bit
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_r <= `HTR_CTRL_RESET;
            irq_mask_r <= 3'h0;
        end
        else if (ce && wr_commit)
        begin
            if (avs_address == `HTR_OFS_CTRL)
                ctrl_r <= avs_writedata[4:0];
            if (avs_address == `HTR_OFS_IRQ_MASK)
                irq_mask_r <= avs_writedata[`HTR_IRQ_W-1:0];
        end
    end

    // Threshold register, values above 50.0 clamp to forced-on
    // threshold range
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            thr_r <= `HTR_THR_RESET;
        else if (ce && wr_commit && avs_address == `HTR_OFS_THRESH)
            thr_r <= f_clamp_thr(avs_writedata);
    end

    // A write of 0.0 releases a latched alarm
    assign thr_zero_wr = wr_commit && avs_address == `HTR_OFS_THRESH &&
                         f_clamp_thr(avs_writedata) == `HTR_THR_OFF;

    // Latest qualified sample against the threshold
    // below threshold compare
    assign below_thr = {7'h00, thr_r} > sif.sample;

    // Alarm state; a cold heater at first qualified sample reads zero current
    // late heater power
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            alarm_r <= 1'b0;
        else if (ce)
        begin
            if (!pulsed_mode)
                alarm_r <= 1'b0;
            else if (thr_r == `HTR_THR_OFF)
                alarm_r <= 1'b0;
            else if (thr_r == `HTR_THR_FORCE)
                alarm_r <= 1'b1;
            else if (thr_zero_wr)
                alarm_r <= 1'b0;
            else if (sif.sample_valid)
            begin
                if (latch_en)
                    alarm_r <= alarm_r || below_thr;
                else
                    alarm_r <= below_thr;
            end
        end
    end

    // Heater current monitor and sample-seen flag
    // monitor value
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            mon_r <= `HTR_CUR_RESET;
            sampled_r <= 1'b0;
        end
        else if (ce && sif.sample_valid)
        begin
            mon_r <= f_monitor(sif.sample);
            sampled_r <= 1'b1;
        end
    end

    // Events: alarm rises, new sample, overrange
    assign irq_set = {sif.sample_valid && sif.sample >= `HTR_CUR_OVR_LIMIT,
                      sif.sample_valid,
                      pulsed_mode && !alarm_r && thr_r == `HTR_THR_FORCE};

    // Sticky status, write one to clear, set beats clear
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irq_stat_r <= 3'h0;
        else if (ce)
        begin
            if (wr_commit && avs_address == `HTR_OFS_IRQ_STAT)
                irq_stat_r <= (irq_stat_r & ~avs_writedata[`HTR_IRQ_W-1:0]) | irq_set | alarm_rise_ev;
            else
                irq_stat_r <= irq_stat_r | irq_set | alarm_rise_ev;
        end
    end

    // Alarm rising edge, from the compare or from the forced-on threshold
    logic alarm_d_r;
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            alarm_d_r <= 1'b0;
        else if (ce)
            alarm_d_r <= alarm_r;
    end
    assign alarm_rise_ev = {2'b00, alarm_r && !alarm_d_r};

    // Interrupt output and heater drive pass-through
    // drive untouched by alarm
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            irq <= 1'b0;
            heater_drive <= 1'b0;
        end
        else if (ce)
        begin
            irq <= |(irq_stat_r & irq_mask_r);
            heater_drive <= heat_out_on;
        end
    end

    // Route alarm to the assigned output only
    // output assignment
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_out1 <= 1'b0;
            ctrl_out2 <= 1'b0;
            aux_out1 <= 1'b0;
            aux_out2 <= 1'b0;
        end
        else if (ce)
        begin
            ctrl_out1 <= alarm_r && out_sel == heater_alarm_pkg::ASSIGN_CTRL1;
            ctrl_out2 <= alarm_r && out_sel == heater_alarm_pkg::ASSIGN_CTRL2;
            aux_out1 <= alarm_r && out_sel == heater_alarm_pkg::ASSIGN_AUX1;
            aux_out2 <= alarm_r && out_sel == heater_alarm_pkg::ASSIGN_AUX2;
        end
    end

    // Checks on the alarm and monitor paths
    sequence seq_cmp_step;
        ce && pulsed_mode && !latch_en && sif.sample_valid && !thr_zero_wr &&
        thr_r != `HTR_THR_OFF && thr_r != `HTR_THR_FORCE;
    endsequence

    a_pulsed_only: assert property (@(posedge sys_clk) disable iff (rst)
        ce && !pulsed_mode |=> !alarm_r)
        else $error("Alarm set outside pulsed mode");

    a_assign_route: assert property (@(posedge sys_clk) disable iff (rst)
        ce && out_sel == heater_alarm_pkg::ASSIGN_AUX1 |=> aux_out1 == $past(alarm_r) && !ctrl_out1)
        else $error("Alarm not routed to aux 1");

    a_compare_follow: assert property (@(posedge sys_clk) disable iff (rst)
        seq_cmp_step |=> alarm_r == $past(below_thr))
        else $error("Alarm does not follow compare");

    a_thr_clamp: assert property (@(posedge sys_clk) disable iff (rst)
        thr_r <= `HTR_THR_FORCE)
        else $error("Threshold above forced value");

    a_off_forced: assert property (@(posedge sys_clk) disable iff (rst)
        ce && thr_r == `HTR_THR_OFF |=> !alarm_r)
        else $error("Alarm on with zero threshold");

    a_on_forced: assert property (@(posedge sys_clk) disable iff (rst)
        ce && pulsed_mode && thr_r == `HTR_THR_FORCE |=> alarm_r)
        else $error("Alarm off with forced threshold");

    a_latch_hold: assert property (@(posedge sys_clk) disable iff (rst)
        ce && pulsed_mode && latch_en && alarm_r && !thr_zero_wr && thr_r != `HTR_THR_OFF |=> alarm_r)
        else $error("Latched alarm dropped");

    a_drive_pass: assert property (@(posedge sys_clk) disable iff (rst)
        ce |=> heater_drive == $past(heat_out_on))
        else $error("Heater drive altered");

    a_monitor_ovr: assert property (@(posedge sys_clk) disable iff (rst)
        ce && sif.sample_valid && sif.sample >= `HTR_CUR_OVR_LIMIT |=> mon_r == `HTR_CUR_OVR_CODE)
        else $error("Overrange code missing");

    a_monitor_val: assert property (@(posedge sys_clk) disable iff (rst)
        ce && sif.sample_valid && sif.sample < `HTR_CUR_OVR_LIMIT |=> mon_r == $past(sif.sample))
        else $error("Monitor not updated");

    a_bus_answer: assert property (@(posedge sys_clk) disable iff (rst)
        ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("Bus answer late");

endmodule

`default_nettype wire

// File: hdl/heater_alarm_regs.svh
// Register offsets, field positions, reset values and timing constants
`ifndef HEATER_ALARM_REGS_SVH
`define HEATER_ALARM_REGS_SVH

// Register byte offsets
`define HTR_OFS_CTRL 8'h00
`define HTR_OFS_THRESH 8'h04
`define HTR_OFS_MONITOR 8'h08
`define HTR_OFS_STATUS 8'h0C
`define HTR_OFS_IRQ_STAT 8'h10
`define HTR_OFS_IRQ_MASK 8'h14

// Control register fields
`define HTR_CTRL_PULSED 0
`define HTR_CTRL_LATCH 1
`define HTR_CTRL_ASSIGN_LO 2
`define HTR_CTRL_ASSIGN_HI 4
`define HTR_CTRL_RESET 5'h00

// Status and interrupt bit positions
`define HTR_ST_ALARM 0
`define HTR_ST_SAMPLED 1
`define HTR_IRQ_ALARM 0
`define HTR_IRQ_SAMPLE 1
`define HTR_IRQ_OVR 2
`define HTR_IRQ_W 3

// Threshold in tenths of an ampere
`define HTR_THR_W 9
`define HTR_THR_OFF 9'h000
`define HTR_THR_FORCE 9'h1F4
`define HTR_THR_RESET 9'h000

// Current monitor in tenths of an ampere
`define HTR_CUR_W 16
`define HTR_CUR_OVR_LIMIT 16'h0226
`define HTR_CUR_OVR_CODE 16'hFFFF
`define HTR_CUR_RESET 16'h0000

// Least continuous on-time before a sample counts
`define HTR_MIN_ON_MS 190
`define HTR_CLK_KHZ 10000

`endif

// File: hdl/heater_alarm_pkg.sv
// Types shared by the heater burnout alarm modules
package heater_alarm_pkg;

    // Where the alarm result is routed
    typedef enum logic [2:0] {
        ASSIGN_NONE = 3'h0,
        ASSIGN_CTRL1 = 3'h1,
        ASSIGN_CTRL2 = 3'h2,
        ASSIGN_AUX1 = 3'h3,
        ASSIGN_AUX2 = 3'h4
    } out_assign_e;

    // On-time qualifier states, Gray coded along idle, count, qualified
    typedef enum logic [1:0] {
        QS_IDLE = 2'b00,
        QS_COUNT = 2'b01,
        QS_QUAL = 2'b11
    } qual_state_e;

    typedef logic [15:0] current_t;

endpackage

// File: hdl/sample_if.sv
// Carrier between the alarm core and the on-time qualified sampler
`timescale 1ns/10ps
`default_nettype none

interface sample_if;
    logic heat_on;
    heater_alarm_pkg::current_t meas;
    logic meas_valid;
    heater_alarm_pkg::current_t sample;
    logic sample_valid;
    logic qualified;

    modport core (output heat_on, output meas, output meas_valid,
                  input sample, input sample_valid, input qualified);
    modport sampler (input heat_on, input meas, input meas_valid,
                     output sample, output sample_valid, output qualified);
endinterface

`default_nettype wire

// File: hdl/qualified_sampler.sv
// Output on-time qualifier and holder of the last qualified current sample
`timescale 1ns/10ps
`default_nettype none
`include "heater_alarm_regs.svh"

module qualified_sampler #(
    parameter int unsigned MIN_ON_CYC = `HTR_MIN_ON_MS * `HTR_CLK_KHZ
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    sample_if.sampler sif
);

    heater_alarm_pkg::qual_state_e state_r;
    logic [31:0] on_cnt_r;
    heater_alarm_pkg::current_t sample_r;
    logic sample_valid_r;

    // On-time counter, restarts whenever the output drops
    // continuous on-time
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_r <= heater_alarm_pkg::QS_IDLE;
            on_cnt_r <= 32'h0000_0000;
        end
        else if (ce)
        begin
            case (state_r)
                heater_alarm_pkg::QS_IDLE:
                begin
                    on_cnt_r <= 32'h0000_0001;
                    if (sif.heat_on)
                        state_r <= heater_alarm_pkg::QS_COUNT;
                end
                heater_alarm_pkg::QS_COUNT:
                begin
                    if (!sif.heat_on)
                        state_r <= heater_alarm_pkg::QS_IDLE;
                    else if (on_cnt_r >= MIN_ON_CYC)
                        state_r <= heater_alarm_pkg::QS_QUAL;
                    else
                        on_cnt_r <= on_cnt_r + 32'h0000_0001;
                end
                heater_alarm_pkg::QS_QUAL:
                begin
                    if (!sif.heat_on)
                        state_r <= heater_alarm_pkg::QS_IDLE;
                end
                default:
                    state_r <= heater_alarm_pkg::QS_IDLE;
            endcase
        end
    end

    // Capture only inside a qualified on-interval
    // qualified sample only
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sample_r <= `HTR_CUR_RESET;
            sample_valid_r <= 1'b0;
        end
        else if (ce)
        begin
            sample_valid_r <= 1'b0;
            if (state_r == heater_alarm_pkg::QS_QUAL && sif.heat_on && sif.meas_valid)
            begin
                sample_r <= sif.meas;
                sample_valid_r <= 1'b1;
            end
        end
    end

    assign sif.sample = sample_r;
    assign sif.sample_valid = sample_valid_r;
    assign sif.qualified = (state_r == heater_alarm_pkg::QS_QUAL);

    // Qualified state needs the full on-time behind it
    sequence seq_on_long;
        ce && sif.heat_on && state_r == heater_alarm_pkg::QS_COUNT && on_cnt_r >= MIN_ON_CYC;
    endsequence

    a_sample_qualified: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(sif.qualified) |-> $past(on_cnt_r) >= MIN_ON_CYC)
        else $error("Qualified without full on-time");

    a_sample_source: assert property (@(posedge sys_clk) disable iff (rst)
        ce && sif.qualified && sif.heat_on && sif.meas_valid |=> sample_valid_r && sample_r == $past(sif.meas))
        else $error("Qualified sample not captured");

    a_drop_unqual: assert property (@(posedge sys_clk) disable iff (rst)
        ce && !sif.heat_on ##1 (ce && sif.heat_on) |-> !sif.qualified ##1 !sif.qualified)
        else $error("Qualified right after output off");

    a_long_on_qual: assert property (@(posedge sys_clk) disable iff (rst)
        seq_on_long |=> sif.qualified)
        else $error("Long on-time not qualified");

endmodule

`default_nettype wire

// File: tb/lead_sensor_model.sv
// Lead current sensor model feeding strobed heater current readings
`timescale 1ns/10ps
`default_nettype none

module lead_sensor_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic heat_on,
    input wire logic [15:0] level,
    output logic [15:0] reading,
    output logic reading_valid
);
    logic [1:0] cnt;
    logic [15:0] last;

    // single-phase on/off load, current flows only while output on
    always_ff @(posedge sys_clk)
    begin
        cnt <= rst ? 2'h0 : cnt + 2'h1;
        reading_valid <= !rst && cnt == 2'h3;
        if (rst)
        begin
            last <= 16'h0000;
            reading <= 16'h0000;
        end
        else if (cnt == 2'h3)
        begin
            last <= heat_on ? level : 16'h0000;
            reading <= heat_on ? level : 16'h0000;
        end
        else
        begin
            // Between strobes the lines carry the inverted last reading
            reading <= ~last;
        end
    end
endmodule

`default_nettype wire

// File: tb/heater_open_alarm_test.sv
// Self-checking bench for the heater burnout alarm block
`timescale 1ns/10ps
`default_nettype none
`include "heater_alarm_regs.svh"

module heater_open_alarm_test;
    localparam int unsigned MIN_ON = 20;
    localparam int unsigned RUN = MIN_ON + 16;
    logic sys_clk;
    logic rst;
    logic ce;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic heat_out_on;
    logic [15:0] level;
    logic [15:0] sensor;
    logic sensor_valid;
    logic heater_drive;
    logic ctrl_out1;
    logic ctrl_out2;
    logic aux_out1;
    logic aux_out2;
    logic irq;
    logic [31:0] q;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;

    heater_open_alarm #(.MIN_ON_CYC(MIN_ON)) uut (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .heat_out_on(heat_out_on), .lead_current_sensor(sensor),
        .lead_current_valid(sensor_valid), .heater_drive(heater_drive), .ctrl_out1(ctrl_out1),
        .ctrl_out2(ctrl_out2), .aux_out1(aux_out1), .aux_out2(aux_out2), .irq(irq));

    lead_sensor_model ct (.sys_clk(sys_clk), .rst(rst), .heat_on(heat_out_on), .level(level),
        .reading(sensor), .reading_valid(sensor_valid));

    // Clock, 100 ns period
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    task print_verdict;
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, seen, exp);
        end
    endtask

    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 100);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        check(n < 100, 1'b1, "bus answer");
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    task automatic heat_run(input logic [15:0] cur, input int unsigned on_cyc);
        @(posedge sys_clk);
        level <= cur;
        heat_out_on <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check(heater_drive, 1'b1, "drive on");
        repeat (on_cyc - 3) @(posedge sys_clk);
        heat_out_on <= 1'b0;
        repeat (8) @(posedge sys_clk);
        check(heater_drive, 1'b0, "drive off");
    endtask

    task automatic expect_alarm(input logic a, input logic [3:0] outs);
        rd(`HTR_OFS_STATUS);
        check(q[0], a, "alarm bit");
        check({aux_out2, aux_out1, ctrl_out2, ctrl_out1}, outs, "alarm outputs");
    endtask

    task automatic t_reset();
        rd(`HTR_OFS_CTRL);
        check(q, 32'h0000_0000, "ctrl reset");
        rd(`HTR_OFS_THRESH);
        check(q, 32'h0000_0000, "thresh reset");
        rd(`HTR_OFS_MONITOR);
        check(q, 32'h0000_0000, "monitor reset");
        rd(`HTR_OFS_IRQ_MASK);
        check(q, 32'h0000_0000, "mask reset");
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40);
        check(q, 32'h0000_0000, "unmapped");
        check(irq, 1'b0, "irq reset");
        // Clock enable low freezes the drive copy
        @(posedge sys_clk);
        ce <= 1'b0;
        heat_out_on <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check(heater_drive, 1'b0, "frozen drive");
        heat_out_on <= 1'b0;
        ce <= 1'b1;
    endtask

    task automatic t_qualify();
        wr(`HTR_OFS_CTRL, 32'h0000_0005);
        wr(`HTR_OFS_THRESH, 32'h0000_0019);
        heat_run(16'h0000, 10);
        rd(`HTR_OFS_STATUS);
        check(q[1:0], 2'h0, "short on-time ignored");
        heat_run(16'h0000, RUN);
        expect_alarm(1'b1, 4'h1);
        rd(`HTR_OFS_STATUS);
        check(q[1], 1'b1, "sample taken");
    endtask

    task automatic t_compare();
        // thresholds 2.5 and 12.5 A are means of normal and burnout current; 0.1 and 49.9 A sit at the range ends
        // gaps of 5 A; three heaters, one lost; totals under 50 A
        logic [31:0] thr [8] = '{32'h19, 32'h19, 32'h01, 32'h01, 32'h1F3, 32'h1F3, 32'h7D, 32'h7D};
        logic [15:0] cur [8] = '{16'h32, 16'h00, 16'h00, 16'h01, 16'h1F2, 16'h1F3, 16'h64, 16'h96};
        logic al [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 8; i++)
        begin
            wr(`HTR_OFS_THRESH, thr[i]);
            heat_run(cur[i], RUN);
            expect_alarm(al[i], {3'h0, al[i]});
            rd(`HTR_OFS_MONITOR);
            check(q, {16'h0000, cur[i]}, "monitor");
        end
    endtask

    task automatic t_force();
        wr(`HTR_OFS_THRESH, 32'h0000_0019);
        heat_run(16'h0000, RUN);
        wr(`HTR_OFS_THRESH, 32'h0000_0000);
        expect_alarm(1'b0, 4'h0);
        wr(`HTR_OFS_THRESH, 32'h0000_01F4);
        heat_run(16'h012C, RUN);
        expect_alarm(1'b1, 4'h1);
        for (int k = 0; k < 6; k++)
        begin
            wr(`HTR_OFS_CTRL, {27'h0, 3'(k), 2'b01});
            expect_alarm(1'b1, (k >= 1 && k <= 4) ? 4'(1 << (k - 1)) : 4'h0);
        end
        wr(`HTR_OFS_THRESH, 32'h0000_01FF);
        rd(`HTR_OFS_THRESH);
        check(q, 32'h0000_01F4, "thresh ceiling");
    endtask

    task automatic t_latch();
        wr(`HTR_OFS_CTRL, 32'h0000_0007);
        wr(`HTR_OFS_THRESH, 32'h0000_0019);
        heat_run(16'h0000, RUN);
        heat_run(16'h0032, RUN);
        expect_alarm(1'b1, 4'h1);
        wr(`HTR_OFS_THRESH, 32'h0000_0000);
        wr(`HTR_OFS_THRESH, 32'h0000_0019);
        expect_alarm(1'b0, 4'h0);
        wr(`HTR_OFS_CTRL, 32'h0000_0005);
        heat_run(16'h0000, RUN);
        heat_run(16'h0032, RUN);
        expect_alarm(1'b0, 4'h0);
        wr(`HTR_OFS_CTRL, 32'h0000_0007);
        heat_run(16'h0000, RUN);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        expect_alarm(1'b0, 4'h0);
    endtask

    task automatic t_pulsed_only();
        wr(`HTR_OFS_CTRL, 32'h0000_0004);
        wr(`HTR_OFS_THRESH, 32'h0000_0019);
        heat_run(16'h0000, RUN);
        expect_alarm(1'b0, 4'h0);
        wr(`HTR_OFS_THRESH, 32'h0000_01F4);
        expect_alarm(1'b0, 4'h0);
    endtask

    task automatic t_overrange();
        wr(`HTR_OFS_CTRL, 32'h0000_0005);
        wr(`HTR_OFS_THRESH, 32'h0000_0019);
        heat_run(16'h0225, RUN);
        rd(`HTR_OFS_MONITOR);
        check(q, 32'h0000_0225, "below overrange");
        heat_run(16'h0226, RUN);
        rd(`HTR_OFS_MONITOR);
        check(q, 32'h0000_FFFF, "overrange code");
    endtask

    task automatic t_irq();
        wr(`HTR_OFS_IRQ_STAT, 32'h0000_0007);
        wr(`HTR_OFS_IRQ_MASK, 32'h0000_0001);
        wr(`HTR_OFS_THRESH, 32'h0000_0000);
        repeat (4) @(posedge sys_clk);
        check(irq, 1'b0, "irq idle");
        wr(`HTR_OFS_THRESH, 32'h0000_01F4);
        repeat (4) @(posedge sys_clk);
        check(irq, 1'b1, "irq on alarm");
        wr(`HTR_OFS_IRQ_STAT, 32'h0000_0001);
        repeat (4) @(posedge sys_clk);
        check(irq, 1'b0, "irq cleared");
        wr(`HTR_OFS_IRQ_MASK, 32'h0000_0000);
        wr(`HTR_OFS_THRESH, 32'h0000_0000);
        wr(`HTR_OFS_THRESH, 32'h0000_01F4);
        repeat (4) @(posedge sys_clk);
        check(irq, 1'b0, "irq masked");
        rd(`HTR_OFS_IRQ_STAT);
        check(q[0], 1'b1, "sticky alarm bit");
        wr(`HTR_OFS_IRQ_MASK, 32'h0000_0004);
        heat_run(16'h0226, RUN);
        check(irq, 1'b1, "irq overrange");
        wr(`HTR_OFS_IRQ_STAT, 32'h0000_0007);
        repeat (4) @(posedge sys_clk);
        check(irq, 1'b0, "irq overrange cleared");
    endtask

    // Main sequence
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        heat_out_on = 1'b0;
        level = 16'h0000;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_qualify();
        t_compare();
        t_force();
        t_latch();
        t_pulsed_only();
        t_overrange();
        t_irq();
        print_verdict();
    end
endmodule

`default_nettype wire
